// [ctv_pkg.sv]
`default_nettype none

package ctv_pkg;

    // ==========================================================
    // Register map
    // ==========================================================
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIELD_W = 2;

    localparam logic [ADDR_W-1:0] OFFSET_TIMER   = 8'h0d;
    localparam logic [ADDR_W-1:0] OFFSET_VOLTAGE = 8'h0e;
    localparam logic [ADDR_W-1:0] OFFSET_TEMP    = 8'h0f;

    localparam logic [DATA_W-1:0] RESET_TIMER   = 8'h2e;
    localparam logic [DATA_W-1:0] RESET_VOLTAGE = 8'h36;
    localparam logic [DATA_W-1:0] RESET_TEMP    = 8'h50;
    localparam logic [DATA_W-1:0] READ_UNMAPPED = 8'h00;

    // ==========================================================
    // Field positions (least significant bit of each 2-bit field)
    // ==========================================================
    localparam int unsigned PRECHARGE_LSB = 0;
    localparam int unsigned FAST_LSB      = 2;
    localparam int unsigned MAINTAIN_LSB  = 4;
    localparam int unsigned RESERVED_LSB  = 6;
    localparam int unsigned ENTRY_LSB     = 0;
    localparam int unsigned HYST_LSB      = 2;
    localparam int unsigned REGV_LSB      = 4;
    localparam int unsigned RECHARGE_LSB  = 6;
    localparam int unsigned WARM_I_LSB    = 0;
    localparam int unsigned COOL_I_LSB    = 2;
    localparam int unsigned WARM_V_LSB    = 4;
    localparam int unsigned COOL_V_LSB    = 6;

    // ==========================================================
    // Code tables, entry for code 3 first, code 0 last
    // ==========================================================
    localparam logic [4*8-1:0]  PRECHARGE_MIN_TABLE = {8'hf0, 8'h78, 8'h3c, 8'h1e};
    localparam logic [4*10-1:0] FAST_MIN_TABLE      = {10'h258, 10'h12c, 10'h096, 10'h04b};
    localparam logic [4*6-1:0]  MAINTAIN_MIN_TABLE  = {6'h3c, 6'h00, 6'h0f, 6'h1e};
    localparam logic [4*13-1:0] ENTRY_MV_TABLE      = {13'h1004, 13'h0fa0, 13'h0f3c, 13'h0ed8};
    localparam logic [4*9-1:0]  HYST_MV_TABLE       = {9'h12c, 9'h0fa, 9'h0c8, 9'h096};
    localparam logic [4*13-1:0] REGULATION_MV_TABLE = {13'h1068, 13'h1036, 13'h1004, 13'h0fd2};
    localparam logic [4*9-1:0]  RECHARGE_MV_TABLE   = {9'h0c8, 9'h12c, 9'h0fa, 9'h15e};
    localparam logic [4*7-1:0]  CURRENT_PCT_TABLE   = {7'h19, 7'h32, 7'h4b, 7'h64};
    localparam logic [4*8-1:0]  OFFSET_MV_TABLE     = {8'haf, 8'h7d, 8'h96, 8'h64};

    // Decoded settings handed to the charger core
    typedef struct packed {
        logic [7:0]  precharge_min;
        logic [9:0]  fast_min;
        logic [5:0]  maintain_min;
        logic [12:0] entry_mv;
        logic [8:0]  hyst_mv;
        logic [12:0] regulation_mv;
        logic [8:0]  recharge_drop_mv;
        logic [6:0]  warm_pct;
        logic [6:0]  cool_pct;
        logic [7:0]  warm_offset_mv;
        logic [7:0]  cool_offset_mv;
        logic [12:0] warm_regulation_mv;
        logic [12:0] cool_regulation_mv;
    } ctv_settings_s;

endpackage

`default_nettype wire

// [ctv_field_decode.sv]
`timescale 1ns/1ps
`default_nettype none

module ctv_field_decode (
    input  wire logic [7:0]             i_timer_cfg,
    input  wire logic [7:0]             i_voltage_cfg,
    input  wire logic [7:0]             i_temp_cfg,
    output var  ctv_pkg::ctv_settings_s o_settings
);

    // ==========================================================
    // Field extraction
    // ==========================================================
    wire logic [1:0] precharge_time_sel        = i_timer_cfg[ctv_pkg::PRECHARGE_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] fast_phase_time_sel       = i_timer_cfg[ctv_pkg::FAST_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] maintain_time_sel         = i_timer_cfg[ctv_pkg::MAINTAIN_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] fast_entry_voltage_sel    = i_voltage_cfg[ctv_pkg::ENTRY_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] fast_entry_hysteresis_sel = i_voltage_cfg[ctv_pkg::HYST_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] regulation_voltage_sel    = i_voltage_cfg[ctv_pkg::REGV_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] recharge_sel              = i_voltage_cfg[ctv_pkg::RECHARGE_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] warm_current_scale        = i_temp_cfg[ctv_pkg::WARM_I_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] cool_current_scale        = i_temp_cfg[ctv_pkg::COOL_I_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] warm_offset_sel           = i_temp_cfg[ctv_pkg::WARM_V_LSB +: ctv_pkg::FIELD_W];
    wire logic [1:0] cool_offset_sel           = i_temp_cfg[ctv_pkg::COOL_V_LSB +: ctv_pkg::FIELD_W];

    // ==========================================================
    // Table lookups
    // ==========================================================
    wire logic [12:0] regulation_mv = ctv_pkg::REGULATION_MV_TABLE[regulation_voltage_sel*13 +: 13];
    wire logic [7:0]  warm_offset   = ctv_pkg::OFFSET_MV_TABLE[warm_offset_sel*8 +: 8];
    wire logic [7:0]  cool_offset   = ctv_pkg::OFFSET_MV_TABLE[cool_offset_sel*8 +: 8];

    // Reserved timer bits are not looked at here, so they cannot steer the charger
    assign o_settings.precharge_min      = ctv_pkg::PRECHARGE_MIN_TABLE[precharge_time_sel*8 +: 8];       // see RULE1
    assign o_settings.fast_min           = ctv_pkg::FAST_MIN_TABLE[fast_phase_time_sel*10 +: 10];          // see RULE2
    assign o_settings.maintain_min       = ctv_pkg::MAINTAIN_MIN_TABLE[maintain_time_sel*6 +: 6];          // see RULE3
    assign o_settings.entry_mv           = ctv_pkg::ENTRY_MV_TABLE[fast_entry_voltage_sel*13 +: 13];       // see RULE4
    assign o_settings.hyst_mv            = ctv_pkg::HYST_MV_TABLE[fast_entry_hysteresis_sel*9 +: 9];       // see RULE5
    assign o_settings.regulation_mv      = regulation_mv;                                                  // see RULE6
    assign o_settings.recharge_drop_mv   = ctv_pkg::RECHARGE_MV_TABLE[recharge_sel*9 +: 9];                // see RULE7
    assign o_settings.warm_pct           = ctv_pkg::CURRENT_PCT_TABLE[warm_current_scale*7 +: 7];          // see RULE8
    assign o_settings.cool_pct           = ctv_pkg::CURRENT_PCT_TABLE[cool_current_scale*7 +: 7];          // see RULE9
    assign o_settings.warm_offset_mv     = warm_offset;                                                    // see RULE10
    assign o_settings.cool_offset_mv     = cool_offset;                                                    // see RULE10
    // Offsets never exceed the lowest regulation voltage, so no underflow
    assign o_settings.warm_regulation_mv = regulation_mv - {5'h00, warm_offset};                          // see RULE10
    assign o_settings.cool_regulation_mv = regulation_mv - {5'h00, cool_offset};                          // see RULE10

endmodule

`default_nettype wire

// [ctv_charger_cfg.sv]
// Functional notes
// RULE1: Timer bits 1:0 pick a precharge time of 30, 60, 120 or 240 minutes, default code 10.
// RULE2: Timer bits 3:2 pick a fast and top-off time of 75, 150, 300 or 600 minutes, default code 11.
// RULE3: Timer bits 5:4 pick a maintain time, 10 is 0, 01 is 15, 00 is 30 and 11 is 60 minutes, default 10.
// RULE4: Voltage bits 1:0 pick the fast-charge entry level of 3.8, 3.9, 4.0 or 4.1 V, default code 10.
// RULE5: Voltage bits 3:2 pick the falling hysteresis of 150, 200, 250 or 300 mV, default code 01.
// RULE6: Voltage bits 5:4 pick the regulation voltage of 4.05, 4.10, 4.15 or 4.20 V, default code 11.
// RULE7: Voltage bits 7:6 pick the recharge drop, 00 is 350, 10 is 300, 01 is 250 and 11 is 200 mV, default 00.
// RULE8: Temperature bits 1:0 scale warm-range fast current to 100, 75, 50 or 25 percent, default 00.
// RULE9: Temperature bits 3:2 scale cool-range fast current to 100, 75, 50 or 25 percent, default 00.
// RULE10: Temperature bits 5:4 and 7:6 give warm and cool regulation offsets of 100, 150, 125 or 175 mV, default 01.
// RULE11: Access only works while input power is good, and reset or loss of power restores all defaults.
// RULE12: Timer bits 7:6 are reserved read/write bits that reset to zero and steer nothing.
`timescale 1ns/1ps
`default_nettype none

module ctv_charger_cfg (
    input  wire logic                   I_CLOCK,
    input  wire logic                   I_RST,
    input  wire logic                   I_POWER_GOOD,
    input  wire logic [7:0]             I_REG_ADDR,
    input  wire logic [7:0]             I_REG_WDATA,
    input  wire logic                   I_REG_WR,
    input  wire logic                   I_REG_RD,
    output var  logic [7:0]             O_REG_RDATA,
    output var  logic                   O_REG_ACK,
    output var  ctv_pkg::ctv_settings_s O_SETTINGS
);

    // ==========================================================
    // Access decode
    // ==========================================================
    // The serial engine only reaches us while input power is good
    wire logic access_ok   = I_POWER_GOOD;                                      // see RULE11
    wire logic restore     = I_RST | ~I_POWER_GOOD;                             // see RULE11
    wire logic hit_timer   = (I_REG_ADDR == ctv_pkg::OFFSET_TIMER);
    wire logic hit_voltage = (I_REG_ADDR == ctv_pkg::OFFSET_VOLTAGE);
    wire logic hit_temp    = (I_REG_ADDR == ctv_pkg::OFFSET_TEMP);
    wire logic wr_taken    = I_REG_WR & access_ok;
    wire logic rd_taken    = I_REG_RD & access_ok;
    wire logic wr_timer    = wr_taken & hit_timer;
    wire logic wr_voltage  = wr_taken & hit_voltage;
    wire logic wr_temp     = wr_taken & hit_temp;

    // ==========================================================
    // Configuration registers
    // ==========================================================
    logic [7:0] timer_reg;
    logic [7:0] voltage_reg;
    logic [7:0] temp_reg;
    logic [7:0] timer_next;
    logic [7:0] voltage_next;
    logic [7:0] temp_next;

    // Reserved bits 7:6 are kept as written so software reads them back
    assign timer_next   = wr_timer   ? I_REG_WDATA : timer_reg;                 // see RULE12
    assign voltage_next = wr_voltage ? I_REG_WDATA : voltage_reg;
    assign temp_next    = wr_temp    ? I_REG_WDATA : temp_reg;

    always_ff @(posedge I_CLOCK) begin
        if (restore) begin
            timer_reg   <= ctv_pkg::RESET_TIMER;                                // see RULE11
            voltage_reg <= ctv_pkg::RESET_VOLTAGE;
            temp_reg    <= ctv_pkg::RESET_TEMP;
        end else begin
            timer_reg   <= timer_next;
            voltage_reg <= voltage_next;
            temp_reg    <= temp_next;
        end
    end

    // ==========================================================
    // Read path
    // ==========================================================
    logic [7:0] rdata_reg;
    logic       ack_reg;
    logic [7:0] read_mux;
    logic [7:0] rdata_next;

    // Unmapped offsets answer with zero rather than stalling the serial engine
    assign read_mux = hit_timer   ? timer_reg   :
                      hit_voltage ? voltage_reg :
                      hit_temp    ? temp_reg    : ctv_pkg::READ_UNMAPPED;
    assign rdata_next = rd_taken ? read_mux : ctv_pkg::READ_UNMAPPED;

    always_ff @(posedge I_CLOCK) begin
        if (I_RST) begin
            rdata_reg <= ctv_pkg::READ_UNMAPPED;
            ack_reg   <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            ack_reg   <= wr_taken | rd_taken;                                   // see RULE11
        end
    end

    assign O_REG_RDATA = rdata_reg;
    assign O_REG_ACK   = ack_reg;

    // ==========================================================
    // Decoded settings
    // ==========================================================
    ctv_pkg::ctv_settings_s settings_comb;
    ctv_pkg::ctv_settings_s settings_reg;

    ctv_field_decode u_decode (
        .i_timer_cfg   (timer_reg),
        .i_voltage_cfg (voltage_reg),
        .i_temp_cfg    (temp_reg),
        .o_settings    (settings_comb)
    );

    // One cycle behind the registers; keeps every output straight from a flop
    always_ff @(posedge I_CLOCK) begin
        settings_reg <= settings_comb;
    end

    assign O_SETTINGS = settings_reg;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (I_RST);

    chk_restore_defaults: assert property ( // see RULE11
        !I_POWER_GOOD |=> (timer_reg == ctv_pkg::RESET_TIMER) && (voltage_reg == ctv_pkg::RESET_VOLTAGE) &&
        (temp_reg == ctv_pkg::RESET_TEMP)
    ) else $error("Defaults not restored after power loss");

    chk_refused_access: assert property ( // see RULE11
        (!I_POWER_GOOD && (I_REG_WR || I_REG_RD)) |=> !O_REG_ACK && (O_REG_RDATA == 8'h00)
    ) else $error("Access answered while power not good");

    chk_write_readback: assert property ( // see RULE11
        (wr_voltage && !I_REG_RD) ##1 (I_POWER_GOOD && I_REG_RD && hit_voltage && !I_REG_WR)
        |=> O_REG_RDATA == $past(I_REG_WDATA, 2)
    ) else $error("Voltage register readback differs from write");

    chk_precharge_code: assert property ( // see RULE1
        (timer_reg[1:0] == 2'b11) |=> O_SETTINGS.precharge_min == 8'hf0
    ) else $error("Precharge code 11 not 240 minutes");

    chk_fast_code: assert property ( // see RULE2
        (timer_reg[3:2] == 2'b00) |=> O_SETTINGS.fast_min == 10'h04b
    ) else $error("Fast timer code 00 not 75 minutes");

    chk_maintain_code: assert property ( // see RULE3
        (timer_reg[5:4] == 2'b10) |=> O_SETTINGS.maintain_min == 6'h00
    ) else $error("Maintain code 10 not zero minutes");

    chk_entry_code: assert property ( // see RULE4
        (voltage_reg[1:0] == 2'b01) |=> O_SETTINGS.entry_mv == 13'h0f3c
    ) else $error("Entry code 01 not 3.9 V");

    chk_hyst_code: assert property ( // see RULE5
        (voltage_reg[3:2] == 2'b10) |=> O_SETTINGS.hyst_mv == 9'h0fa
    ) else $error("Hysteresis code 10 not 250 mV");

    chk_regulation_code: assert property ( // see RULE6
        (voltage_reg[5:4] == 2'b00) |=> O_SETTINGS.regulation_mv == 13'h0fd2
    ) else $error("Regulation code 00 not 4.05 V");

    chk_recharge_code: assert property ( // see RULE7
        (voltage_reg[7:6] == 2'b10) |=> O_SETTINGS.recharge_drop_mv == 9'h12c
    ) else $error("Recharge code 10 not 300 mV");

    chk_warm_current: assert property ( // see RULE8
        (temp_reg[1:0] == 2'b01) |=> O_SETTINGS.warm_pct == 7'h4b
    ) else $error("Warm scale code 01 not 75 percent");

    chk_cool_current: assert property ( // see RULE9
        (temp_reg[3:2] == 2'b11) |=> O_SETTINGS.cool_pct == 7'h19
    ) else $error("Cool scale code 11 not 25 percent");

    chk_offset_apply: assert property ( // see RULE10
        (temp_reg[5:4] == 2'b10) && (temp_reg[7:6] == 2'b01) |=>
        (O_SETTINGS.warm_offset_mv == 8'h7d) && (O_SETTINGS.cool_offset_mv == 8'h96) &&
        (O_SETTINGS.warm_regulation_mv == O_SETTINGS.regulation_mv - 13'h007d)
    ) else $error("Regulation offsets wrong");

    chk_reserved_inert: assert property ( // see RULE12
        (wr_timer && (I_REG_WDATA[5:0] == timer_reg[5:0]) && I_POWER_GOOD) ##1 I_POWER_GOOD
        |=> $stable(O_SETTINGS)
    ) else $error("Reserved timer bits changed the settings");

    chk_ack_after_strobe: assert property ( // see RULE11
        (I_POWER_GOOD && (I_REG_WR || I_REG_RD)) |=> O_REG_ACK
    ) else $error("Accepted access not acknowledged");

    chk_idle_rdata: assert property ( // see RULE11
        !(I_POWER_GOOD && I_REG_RD) |=> (O_REG_RDATA == ctv_pkg::READ_UNMAPPED)
    ) else $error("Read data not zero outside a read answer");

    // Own disable term so that the reset itself is watched
    chk_reset_defaults: assert property ( // see RULE11
        @(posedge I_CLOCK) disable iff (1'b0)
        I_RST |=> (timer_reg == ctv_pkg::RESET_TIMER) && (voltage_reg == ctv_pkg::RESET_VOLTAGE) &&
        (temp_reg == ctv_pkg::RESET_TEMP) && !O_REG_ACK
    ) else $error("Defaults not loaded by reset");

endmodule

`default_nettype wire

// [ctv_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ctv_host_model (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_rdata,
    input  wire logic       i_ack,
    output var  logic [7:0] o_addr,
    output var  logic [7:0] o_wdata,
    output var  logic       o_wr,
    output var  logic       o_rd,
    output var  logic       o_power_good
);
    initial begin
        o_addr       = 8'h00;
        o_wdata      = 8'h00;
        o_wr         = 1'b0;
        o_rd         = 1'b0;
        o_power_good = 1'b1;
    end

    // Power stays good around normal traffic; dropping it is a scenario of its own
    task automatic set_power(input logic good);
        @(negedge i_clock);
        o_power_good = good;
    endtask

    // One-cycle strobe, answer taken in the ack cycle; released address and data lines show the inverse
    task automatic access(input logic is_wr, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic k);
        @(negedge i_clock);
        o_addr  = a;
        o_wdata = d;
        o_wr    = is_wr;
        o_rd    = !is_wr;
        @(negedge i_clock);
        q       = i_rdata;
        k       = i_ack;
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
    endtask

    // Write, then read the same offset in the very next cycle with no idle gap
    task automatic write_read(input logic [7:0] a, input logic [7:0] d,
                              output logic [7:0] q, output logic kw, output logic kr);
        @(negedge i_clock);
        o_addr  = a;
        o_wdata = d;
        o_wr    = 1'b1;
        o_rd    = 1'b0;
        @(negedge i_clock);
        kw      = i_ack;
        o_wr    = 1'b0;
        o_rd    = 1'b1;
        @(negedge i_clock);
        q       = i_rdata;
        kr      = i_ack;
        o_rd    = 1'b0;
        o_addr  = ~a;
        o_wdata = ~d;
    endtask
endmodule

`default_nettype wire

// [testbench.sv]
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s expected %0h seen %0h", nm, e, g); end end

module testbench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr, wdata, rdata;
    logic wr, rd, ack, pg;
    ctv_pkg::ctv_settings_s settings;
    int fail_count = 0;
    int n_checks = 0;
    logic [7:0] q;
    logic k;
    logic kw;
    logic [7:0] w;
    logic [12:0] pre_min[4] = '{30, 60, 120, 240};
    logic [12:0] fast_min[4] = '{75, 150, 300, 600};
    logic [12:0] mnt_min[4] = '{30, 15, 0, 60};
    logic [12:0] ent_mv[4] = '{3800, 3900, 4000, 4100};
    logic [12:0] hys_mv[4] = '{150, 200, 250, 300};
    logic [12:0] reg_mv[4] = '{4050, 4100, 4150, 4200};
    logic [12:0] rch_mv[4] = '{350, 250, 300, 200};
    logic [12:0] pct[4] = '{100, 75, 50, 25};
    logic [12:0] off_mv[4] = '{100, 150, 125, 175};

    always #12.5 clk = ~clk;

    ctv_host_model ctv_host_model_inst (.i_clock(clk), .i_rdata(rdata), .i_ack(ack), .o_addr(addr),
        .o_wdata(wdata), .o_wr(wr), .o_rd(rd), .o_power_good(pg));

    ctv_charger_cfg ctv_charger_cfg_inst (.I_CLOCK(clk), .I_RST(rst), .I_POWER_GOOD(pg), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata), .O_REG_ACK(ack),
        .O_SETTINGS(settings));

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Expected decode worked out field by field from the written codes
    task automatic check_set(input logic [7:0] t, input logic [7:0] v, input logic [7:0] m);
        `CHK("precharge", pre_min[t[1:0]], settings.precharge_min)
        `CHK("fast", fast_min[t[3:2]], settings.fast_min)
        `CHK("maintain", mnt_min[t[5:4]], settings.maintain_min)
        `CHK("entry", ent_mv[v[1:0]], settings.entry_mv)
        `CHK("hyst", hys_mv[v[3:2]], settings.hyst_mv)
        `CHK("regulation", reg_mv[v[5:4]], settings.regulation_mv)
        `CHK("recharge", rch_mv[v[7:6]], settings.recharge_drop_mv)
        `CHK("warm pct", pct[m[1:0]], settings.warm_pct)
        `CHK("cool pct", pct[m[3:2]], settings.cool_pct)
        `CHK("warm off", off_mv[m[5:4]], settings.warm_offset_mv)
        `CHK("cool off", off_mv[m[7:6]], settings.cool_offset_mv)
        `CHK("warm reg", reg_mv[v[5:4]] - off_mv[m[5:4]], settings.warm_regulation_mv)
        `CHK("cool reg", reg_mv[v[5:4]] - off_mv[m[7:6]], settings.cool_regulation_mv)
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        ctv_host_model_inst.access(1'b0, a, 8'h00, q, k);
        `CHK("read ack", 1'b1, k)
        `CHK("read data", e, q)
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [7:0] d, input logic e);
        ctv_host_model_inst.access(1'b1, a, d, q, k);
        `CHK("write ack", e, k)
    endtask

    task automatic defaults();
        rd_chk(8'h0d, 8'h2e);
        rd_chk(8'h0e, 8'h36);
        rd_chk(8'h0f, 8'h50);
        check_set(8'h2e, 8'h36, 8'h50);
    endtask

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        defaults();
        wr_chk(8'h10, 8'h5a, 1'b1);
        rd_chk(8'h10, 8'h00);
        // Every code of every field at once, then read back
        for (int c = 0; c < 4; c++) begin
            w = {4{c[1:0]}};
            wr_chk(8'h0d, w, 1'b1);
            wr_chk(8'h0e, w, 1'b1);
            wr_chk(8'h0f, w, 1'b1);
            rd_chk(8'h0d, w);
            rd_chk(8'h0e, w);
            rd_chk(8'h0f, w);
            check_set(w, w, w);
        end
        // Reserved timer bits store but steer nothing
        wr_chk(8'h0d, 8'h2e, 1'b1);
        rd_chk(8'h0d, 8'h2e);
        check_set(8'h2e, 8'hff, 8'hff);
        wr_chk(8'h0d, 8'hee, 1'b1);
        rd_chk(8'h0d, 8'hee);
        check_set(8'h2e, 8'hff, 8'hff);
        // A read right behind a write returns the new byte
        ctv_host_model_inst.write_read(8'h0e, 8'h9c, q, kw, k);
        `CHK("b2b write ack", 1'b1, kw)
        `CHK("b2b read ack", 1'b1, k)
        `CHK("b2b read data", 8'h9c, q)
        // Loss of input power refuses access and restores defaults
        ctv_host_model_inst.set_power(1'b0);
        wr_chk(8'h0d, 8'h00, 1'b0);
        ctv_host_model_inst.access(1'b0, 8'h0e, 8'h00, q, k);
        `CHK("refused read ack", 1'b0, k)
        `CHK("refused read data", 8'h00, q)
        ctv_host_model_inst.set_power(1'b1);
        defaults();
        // A reset in mid-run puts every changed byte back
        wr_chk(8'h0d, 8'h15, 1'b1);
        wr_chk(8'h0e, 8'h9c, 1'b1);
        wr_chk(8'h0f, 8'h0a, 1'b1);
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        defaults();
        results();
    end

    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        results();
    end
endmodule

`default_nettype wire
